// ===== common/fetch_regs.vh
// register map, field positions, encodings and reset values for the
// instruction fetch and pipeline sequencer; definitions only
`ifndef FETCH_REGS_VH
`define FETCH_REGS_VH

// ************************************************************
// apb register offsets (byte addresses)
// ************************************************************
`define OFS_PCL 8'h00
`define OFS_CTRL 8'h04
`define OFS_STAT 8'h08
`define OFS_ACC 8'h0c
`define OFS_PM_ADDR 8'h10
`define OFS_PM_DATA 8'h14
`define OFS_EXEC 8'h18

// ************************************************************
// field positions
// ************************************************************
`define CTRL_RUN_BIT 0
`define CTRL_INT_BIT 1
`define STAT_PHASE_LSB 16
`define STAT_VALID_BIT 20
`define STAT_INTP_BIT 21
`define STAT_PCLP_BIT 22

// ************************************************************
// widths, vectors and reset values
// ************************************************************
`define PC_W 11
`define IW 15
`define PM_DEPTH 2048
`define RESET_VEC 11'h000
`define INT_VEC 11'h004
`define ACC_RST 8'h00

// ************************************************************
// phases of one instruction cycle
// ************************************************************
`define PH_T1 2'h0
`define PH_T2 2'h1
`define PH_T3 2'h2
`define PH_T4 2'h3

// ************************************************************
// instruction classes, bits [14:12]
// ************************************************************
`define CLS_NOP 3'h0
`define CLS_ALU 3'h1
`define CLS_JMP 3'h2
`define CLS_CALL 3'h3
`define CLS_RET 3'h4
`define CLS_SZ 3'h5
`define CLS_SNZ 3'h6
`define CLS_MOVPCL 3'h7

// ************************************************************
// alu operations, bits [11:8]
// ************************************************************
`define ALU_ADD 4'h0
`define ALU_SUB 4'h1
`define ALU_AND 4'h2
`define ALU_OR 4'h3
`define ALU_XOR 4'h4
`define ALU_CPL 4'h5
`define ALU_RR 4'h6
`define ALU_RL 4'h7
`define ALU_INC 4'h8
`define ALU_DEC 4'h9
`define ALU_MOV 4'ha

`endif

// ===== design/prog_mem.v
// program memory: one write port for loading, one read port whose
// data comes out of a register and holds until the next read
`timescale 1ns/100ps
`default_nettype none
`include "fetch_regs.vh"

module prog_mem
(
	// clock
	input wire pclk,
	// load port
	input wire wr_en,
	input wire [`PC_W-1:0] wr_addr,
	input wire [`IW-1:0] wr_data,
	// fetch port
	input wire rd_en,
	input wire [`PC_W-1:0] rd_addr,
	output reg [`IW-1:0] rd_data
);

	reg [`IW-1:0] mem [0:`PM_DEPTH-1];

	always @(posedge pclk)
	begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
	end

	// no reset on the array or read register; contents come from software
	always @(posedge pclk)
	begin
		if (rd_en)
			rd_data <= mem[rd_addr];
	end

endmodule
`default_nettype wire

// ===== design/alu8.v
// eight bit arithmetic and logic unit, purely combinational
// operand a is the accumulator, operand b the immediate field
`timescale 1ns/100ps
`default_nettype none
`include "fetch_regs.vh"

module alu8
(
	// operands
	input wire [3:0] op,
	input wire [7:0] a,
	input wire [7:0] b,
	// result
	output reg [7:0] y
);

	always @*
	begin
		case (op)
			`ALU_ADD: y = a + b;
			`ALU_SUB: y = a - b;
			`ALU_AND: y = a & b;
			`ALU_OR: y = a | b;
			`ALU_XOR: y = a ^ b;
			`ALU_CPL: y = ~a;
			`ALU_RR: y = {a[0], a[7:1]};
			`ALU_RL: y = {a[6:0], a[7]};
			`ALU_INC: y = a + 8'h01;
			`ALU_DEC: y = a - 8'h01;
			`ALU_MOV: y = b;
			default: y = a;
		endcase
	end

endmodule
`default_nettype wire

// ===== design/fetch_pipeline.v
// instruction fetch and pipeline sequencer with an 11-bit program counter,
// four phase instruction cycle and apb register access.
// assumes a single pclk domain and an apb master on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "fetch_regs.vh"

module fetch_pipeline
(
	// clock and reset
	input wire pclk,
	input wire presetn,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// core state
	output reg [3:0] instruction_phase_clocks,
	output reg [`PC_W-1:0] fetch_pc,
	output reg [7:0] acc_value
);

	// ************************************************************
	// state
	// ************************************************************
	reg [1:0] phase_reg;
	reg run_reg;
	reg fetch_valid_reg;
	reg exec_valid_reg;
	reg [`IW-1:0] exec_reg;
	reg [7:0] alu_res_reg;
	reg [`PC_W-1:0] ret_reg;
	reg int_pend_reg;
	reg pcl_pend_reg;
	reg [7:0] pcl_data_reg;
	reg [`PC_W-1:0] pm_addr_reg;

	wire [`IW-1:0] pm_rdata;
	wire [7:0] alu_y;

	// ************************************************************
	// apb decode
	// ************************************************************
	wire acc_phase = psel & penable;
	wire wr_now = acc_phase & pwrite & pready;
	wire addr_pcl = (paddr == `OFS_PCL);
	wire addr_ctrl = (paddr == `OFS_CTRL);
	wire addr_stat = (paddr == `OFS_STAT);
	wire addr_acc = (paddr == `OFS_ACC);
	wire addr_pma = (paddr == `OFS_PM_ADDR);
	wire addr_pmd = (paddr == `OFS_PM_DATA);
	wire addr_exec = (paddr == `OFS_EXEC);
	wire addr_rw = addr_pcl | addr_ctrl | addr_pma | addr_pmd;
	wire addr_ok = addr_rw | addr_stat | addr_acc | addr_exec;
	wire bad_access = ~addr_ok | (pwrite & ~addr_rw);

	wire wr_pcl = wr_now & addr_pcl;
	wire wr_ctrl = wr_now & addr_ctrl;
	wire wr_pma = wr_now & addr_pma;
	wire wr_pmd = wr_now & addr_pmd;

	// ************************************************************
	// execute stage decode
	// ************************************************************
	wire [2:0] cls = exec_reg[14:12];
	wire [`PC_W-1:0] target = exec_reg[`PC_W-1:0];
	wire acc_zero = (acc_value == 8'h00);
	wire boundary = run_reg & (phase_reg == `PH_T4);

	reg skip_now;
	reg jump_now;
	reg [`PC_W-1:0] jump_addr;
	always @*
	begin
		skip_now = 1'b0;
		jump_now = 1'b0;
		jump_addr = target;
		if (exec_valid_reg)
		begin
			case (cls)
				`CLS_SZ: skip_now = acc_zero;
				`CLS_SNZ: skip_now = ~acc_zero;
				`CLS_JMP: jump_now = 1'b1;
				`CLS_CALL: jump_now = 1'b1;
				`CLS_RET:
				begin
					jump_now = 1'b1;
					jump_addr = ret_reg;
				end
				// program writes low byte, page kept
				`CLS_MOVPCL:
				begin
					jump_now = 1'b1;
					jump_addr = {fetch_pc[`PC_W-1:8], acc_value};
				end
				default: jump_now = 1'b0;
			endcase
		end
	end

	// an instruction's own redirect goes first; bus low byte writes and
	// interrupts wait one more cycle rather than overwrite it
	wire pcl_take = pcl_pend_reg & ~jump_now;
	wire int_take = int_pend_reg & ~jump_now & ~pcl_take & ~skip_now;
	wire redirect = jump_now | pcl_take | int_take;

	reg [`PC_W-1:0] fetch_addr;
	always @*
	begin
		// default is the next sequential address
		fetch_addr = fetch_pc;
		if (jump_now)
			fetch_addr = jump_addr;
		// bus write keeps the high bits
		else if (pcl_take)
			fetch_addr = {fetch_pc[`PC_W-1:8], pcl_data_reg};
		else if (int_take)
			fetch_addr = `INT_VEC;
	end

	// ************************************************************
	// submodules
	// ************************************************************
	// read issued at the start of T1
	prog_mem u_mem
	(
		.pclk(pclk),
		.wr_en(wr_pmd),
		.wr_addr(pm_addr_reg),
		.wr_data(pwdata[`IW-1:0]),
		.rd_en(boundary),
		.rd_addr(fetch_addr),
		.rd_data(pm_rdata)
	);

	alu8 u_alu
	(
		.op(exec_reg[11:8]),
		.a(acc_value),
		.b(exec_reg[7:0]),
		.y(alu_y)
	);

	// ************************************************************
	// phase sequencer
	// ************************************************************
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			phase_reg <= `PH_T4;
			instruction_phase_clocks <= 4'h0;
		end
		else if (run_reg)
		begin
			phase_reg <= phase_reg + 2'h1;
			case (phase_reg)
				`PH_T1: instruction_phase_clocks <= 4'h2;
				`PH_T2: instruction_phase_clocks <= 4'h4;
				`PH_T3: instruction_phase_clocks <= 4'h8;
				`PH_T4: instruction_phase_clocks <= 4'h1;
				default: instruction_phase_clocks <= 4'h0;
			endcase
		end
		else
			instruction_phase_clocks <= 4'h0;
	end

	// ************************************************************
	// program counter and pipeline
	// ************************************************************
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fetch_pc <= `RESET_VEC;
			fetch_valid_reg <= 1'b0;
			exec_valid_reg <= 1'b0;
			exec_reg <= 15'h0000;
			ret_reg <= `RESET_VEC;
		end
		else if (boundary)
		begin
			fetch_pc <= fetch_addr + 11'h001;
			fetch_valid_reg <= 1'b1;
			// word fetched last cycle executes now
			exec_reg <= pm_rdata;
			// taken skip leaves a dummy cycle
			// low byte write also gives a dummy cycle
			exec_valid_reg <= fetch_valid_reg & ~redirect & ~skip_now;
			if ((exec_valid_reg & (cls == `CLS_CALL)) | int_take)
				ret_reg <= fetch_pc - 11'h001;
		end
	end

	// ************************************************************
	// execute: decode T2, alu T3, commit T4
	// ************************************************************
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			alu_res_reg <= 8'h00;
			acc_value <= `ACC_RST;
		end
		else
		begin
			// alu result taken at end of T3
			if (run_reg & (phase_reg == `PH_T3))
				alu_res_reg <= alu_y;
			// result written back at end of T4
			if (boundary & exec_valid_reg & (cls == `CLS_ALU))
				acc_value <= alu_res_reg;
		end
	end

	// ************************************************************
	// pending requests; a new request wins over its own clear
	// ************************************************************
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			int_pend_reg <= 1'b0;
			pcl_pend_reg <= 1'b0;
			pcl_data_reg <= 8'h00;
		end
		else
		begin
			if (wr_ctrl & pwdata[`CTRL_INT_BIT])
				int_pend_reg <= 1'b1;
			else if (boundary & int_take)
				int_pend_reg <= 1'b0;
			// bus write held until the next cycle boundary at which no instruction jumps
			if (wr_pcl)
			begin
				pcl_pend_reg <= 1'b1;
				pcl_data_reg <= pwdata[7:0];
			end
			else if (boundary & pcl_take)
				pcl_pend_reg <= 1'b0;
		end
	end

	// ************************************************************
	// apb registers and answer
	// ************************************************************
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			run_reg <= 1'b0;
			pm_addr_reg <= 11'h000;
		end
		else
		begin
			if (wr_ctrl)
				run_reg <= pwdata[`CTRL_RUN_BIT];
			if (wr_pma)
				pm_addr_reg <= pwdata[`PC_W-1:0];
			else if (wr_pmd)
				pm_addr_reg <= pm_addr_reg + 11'h001;
		end
	end

	// one wait state: ready rises in the second access cycle
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end
		else if (acc_phase & ~pready)
		begin
			pready <= 1'b1;
			pslverr <= bad_access;
			prdata <= 32'h00000000;
			if (~pwrite)
			begin
				// only the low byte of the counter is exposed
				if (addr_pcl)
					prdata <= {24'h000000, fetch_pc[7:0]};
				else if (addr_ctrl)
					prdata <= {31'h00000000, run_reg};
				else if (addr_stat)
					prdata <= {9'h000, pcl_pend_reg, int_pend_reg, exec_valid_reg, 2'h0,
						phase_reg, 16'h0000};
				else if (addr_acc)
					prdata <= {24'h000000, acc_value};
				else if (addr_pma)
					prdata <= {21'h000000, pm_addr_reg};
				else if (addr_exec)
					prdata <= {17'h00000, exec_reg};
			end
		end
		else
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// ===== tb/fetch_pipeline_assertions.sv
// checker for apb timing and the phase and counter sequencing
// assumes a bind onto fetch_pipeline, one pclk domain
`timescale 1ns/100ps
`default_nettype none
`include "fetch_regs.vh"
module fetch_pipeline_assertions
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	// core state
	input wire logic [3:0] instruction_phase_clocks,
	input wire logic [`PC_W-1:0] fetch_pc,
	input wire logic [7:0] acc_value
);
	// ************************************************************
	// properties
	// ************************************************************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_rest_of_cycle;
		instruction_phase_clocks == 4'h2 ##1 instruction_phase_clocks == 4'h4 ##1 instruction_phase_clocks == 4'h8;
	endsequence

	sequence s_one_wait;
		!pready ##1 pready;
	endsequence

	chk_phase_onehot: assert property ($onehot0(instruction_phase_clocks))
		else $error("phase outputs not one-hot");
	chk_phase_order: assert property (instruction_phase_clocks == 4'h1 |=> s_rest_of_cycle)
		else $error("phases out of order");
	chk_phase_wrap: assert property (instruction_phase_clocks == 4'h8 |=> instruction_phase_clocks[3:1] == 3'h0)
		else $error("phase after last is not first or idle");
	chk_pc_at_first: assert property (!$stable(fetch_pc) |-> instruction_phase_clocks == 4'h1)
		else $error("counter moved outside first phase");
	chk_acc_overlap: assert property (!$stable(acc_value) |-> instruction_phase_clocks == 4'h1)
		else $error("accumulator written outside cycle boundary");
	chk_pc_reset: assert property (disable iff (1'b0) $rose(presetn) |-> fetch_pc == `RESET_VEC)
		else $error("counter not at reset vector");
	chk_apb_wait: assert property (psel && !penable |=> s_one_wait)
		else $error("pready not after one wait state");
	chk_pready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_err_unmapped: assert property (pready && paddr > `OFS_EXEC |-> pslverr)
		else $error("unmapped access without error");
	chk_err_qualified: assert property (pslverr |-> pready)
		else $error("error without pready");
endmodule
`default_nettype wire

// ===== tb/prog_image.sv
// program image that the bench loads into program memory
// assumes the bench sets idx and waits an edge before using it
`timescale 1ns/100ps
`default_nettype none
module prog_image
(
	// selection
	input wire logic [2:0] idx,
	// word and its address
	output logic [10:0] addr,
	output logic [14:0] word
);
	// words: mov 5, inc, jmp 302, loop; at 310: inc, skip if nonzero, mov 0, loop
	always_comb
	begin
		case (idx)
			3'h0: {addr, word} = {11'h000, 15'h1a05};
			3'h1: {addr, word} = {11'h001, 15'h1800};
			3'h2: {addr, word} = {11'h002, 15'h2302};
			3'h3: {addr, word} = {11'h302, 15'h2302};
			3'h4: {addr, word} = {11'h310, 15'h1800};
			3'h5: {addr, word} = {11'h311, 15'h6000};
			3'h6: {addr, word} = {11'h312, 15'h1a00};
			default: {addr, word} = {11'h313, 15'h2313};
		endcase
	end
endmodule
`default_nettype wire

// ===== tb/fetch_pipeline_tb.sv
// self-checking bench: loads a program over apb, runs it, jumps by a low byte write
// assumes the design files and fetch_regs.vh are on the include path
`timescale 1ns/100ps
`default_nettype none
`include "fetch_regs.vh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
	$display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module fetch_pipeline_tb;
	logic pclk = 0;
	logic presetn = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [3:0] instruction_phase_clocks;
	logic [10:0] fetch_pc;
	logic [7:0] acc_value;
	logic [2:0] idx = 3'h0;
	logic [10:0] img_addr;
	logic [14:0] img_word;
	logic [31:0] rdata;
	logic rerr;
	int n_errors = 0;
	int comparisons = 0;

	always #5 pclk = ~pclk;

	fetch_pipeline u_fetch_pipeline (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.instruction_phase_clocks(instruction_phase_clocks), .fetch_pc(fetch_pc), .acc_value(acc_value));
	prog_image u_prog_image (.idx(idx), .addr(img_addr), .word(img_word));

	// ************************************************************
	// apb master, waits and verdict
	// ************************************************************
	// no cycle limit here: a missing pready is caught by the watchdog
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		begin
			@(posedge pclk);
			psel <= 1'b1;
			pwrite <= wr;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			do @(posedge pclk); while (pready !== 1'b1);
			rdata = prdata;
			rerr = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	task automatic wait_pc(input logic [10:0] v);
		int n;
		begin
			n = 0;
			while (fetch_pc !== v && n < 400)
			begin
				@(posedge pclk);
				n++;
			end
		end
	endtask

	task print_verdict;
		if (n_errors == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial
	begin
		#200000;
		n_errors++;
		print_verdict;
	end

	// ************************************************************
	// tests
	// ************************************************************
	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		`CHK("pc", 11'h000, fetch_pc)
		apb(1'b0, `OFS_PCL, 32'h0);
		`CHK("pcl", 32'h0, rdata)
		apb(1'b0, 8'h40, 32'h0);
		`CHK("unmapped", 1'b1, rerr)
		for (int i = 0; i < 8; i++)
		begin
			idx = i[2:0];
			@(posedge pclk);
			apb(1'b1, `OFS_PM_ADDR, {21'h0, img_addr});
			apb(1'b1, `OFS_PM_DATA, {17'h0, img_word});
		end
		apb(1'b1, `OFS_CTRL, 32'h1);
		wait_pc(11'h303);
		`CHK("pc", 11'h303, fetch_pc)
		`CHK("acc", 8'h06, acc_value)
		// the low byte write must keep page 3
		apb(1'b1, `OFS_PCL, 32'h10);
		wait_pc(11'h315);
		`CHK("pc", 11'h315, fetch_pc)
		`CHK("acc", 8'h07, acc_value)
		apb(1'b0, `OFS_PCL, 32'h0);
		`CHK("pcl", 7'h0a, rdata[7:1])
		apb(1'b1, `OFS_ACC, 32'hff);
		`CHK("ro", 1'b1, rerr)
		apb(1'b0, `OFS_ACC, 32'h0);
		`CHK("acc", 32'h07, rdata)
		// handler at the vector: dec, then ret back into the jump loop
		apb(1'b1, `OFS_PM_ADDR, {21'h0, `INT_VEC});
		apb(1'b1, `OFS_PM_DATA, 32'h1900);
		apb(1'b1, `OFS_PM_DATA, 32'h4000);
		apb(1'b1, `OFS_CTRL, 32'h3);
		wait_pc(11'h005);
		`CHK("pc", 11'h005, fetch_pc)
		wait_pc(11'h315);
		`CHK("pc", 11'h315, fetch_pc)
		`CHK("acc", 8'h06, acc_value)
		apb(1'b0, `OFS_STAT, 32'h0);
		`CHK("intp", 1'b0, rdata[`STAT_INTP_BIT])
		print_verdict;
	end
endmodule

bind fetch_pipeline fetch_pipeline_assertions u_fetch_pipeline_assertions (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
	.instruction_phase_clocks(instruction_phase_clocks), .fetch_pc(fetch_pc), .acc_value(acc_value));
`default_nettype wire
